// [core/lpei_map.vh]
// Register offsets, field positions, reset values and timing counts of the local pulse input.
`ifndef LPEI_MAP_VH
`define LPEI_MAP_VH
`define LPEI_REG_TYPE 4'h0
`define LPEI_REG_FUNC_A 4'h1
`define LPEI_REG_FUNC_B 4'h2
`define LPEI_REG_SENSE 4'h3
`define LPEI_REG_INVERT 4'h4
`define LPEI_REG_TARGET 4'h5
`define LPEI_REG_COUNT 4'h6
`define LPEI_REG_FREQ 4'h7
`define LPEI_REG_INDEX 4'h8
`define LPEI_REG_POS 4'h9
`define LPEI_REG_STATUS 4'ha
`define LPEI_REG_MASK 4'hb
`define LPEI_REG_PINS 4'hc
`define LPEI_REG_LINES 4'hd
`define LPEI_TYPE_RST 8'h00
`define LPEI_TYPE_A_BIT 0
`define LPEI_TYPE_B_BIT 4
`define LPEI_FUNC_FREQ 2'h0
`define LPEI_FUNC_RSVD 2'h1
`define LPEI_FUNC_ENC 2'h2
`define LPEI_FUNC_RST 2'h0
`define LPEI_SENSE_CARD 1'b0
`define LPEI_SENSE_LOCAL 1'b1
`define LPEI_INV_DIR_BIT 0
`define LPEI_INV_IDX_BIT 1
`define LPEI_ST_REACH 0
`define LPEI_ST_INDEX 1
`define LPEI_ST_GATE 2
`define LPEI_GATE_MS 100
`define LPEI_CLK_KHZ 10000
`define LPEI_GATE_CYC (`LPEI_GATE_MS * `LPEI_CLK_KHZ)
`define LPEI_FREQ_MAX 16'sd32767
`define LPEI_FREQ_MIN -16'sd9999
`endif

// [core/lpei_edge.v]
// Edge detector for one fast input pin.
`timescale 1ns/1ns
module lpei_edge
(
  // Clock and reset.
  input wire core_clk,
  input wire srst,
  // Pin level and detected edges.
  input wire pin,
  output reg level,
  output wire rise,
  output wire fall
);
  // Hold the previous level for comparison.
  always @(posedge core_clk)
  begin
    if (srst)
      level <= 1'b0;
    else
      level <= pin;
  end

  // Pulse one cycle on each change of level.
  assign rise = pin & ~level;
  assign fall = ~pin & level;
endmodule // lpei_edge

// [core/lpei_top.v]
// Local fast pulse and incremental encoder input block with register port.
//
// Overview of operation
// - Input A counts its rising edges when it is a pulse input set to frequency use.
// - When the count reaches or passes the target, a one-cycle reached pulse is output and the count clears.
// - Bit 0 of the type setting makes input A a pulse input (0) or digital input (1), reset 0x00.
// - Bit 4 of the type setting makes input B a pulse input (0) or digital input (1).
// - Input A function is 0 frequency, 1 reserved, 2 encoder paired with B, reset 0.
// - Input B function is 0 frequency, 1 reserved, 2 encoder paired with A, reset 0.
// - Speed source 0 selects the option card feedback, 1 selects the local encoder pair.
// - Encoder frequency is reported signed in 0.1 Hz steps, clamped to its range, reset 0.
// - Direction invert set to 1 flips the sign of the decoded direction.
// - A readable index count follows the position sampled at each index pulse.
// - An index direction reverse option changes only the index reference direction.
`timescale 1ns/1ns
`include "lpei_map.vh"
module lpei_top
#(
  // Gate length in clock cycles and width of the pulse counter.
  parameter GATE_CYC = `LPEI_GATE_CYC,
  parameter CNT_W = 32
)
(
  // Clock and reset.
  input wire core_clk,
  input wire srst,
  // Fast input pins and index pulse.
  input wire fast_input_a,
  input wire fast_input_b,
  input wire index_pulse,
  // Speed feedback from the option card, in 0.1 Hz.
  input wire [15:0] card_frequency,
  // Register port.
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  // Outputs to the drive.
  output reg count_reached,
  output reg digital_a,
  output reg digital_b,
  output reg [15:0] speed_feedback,
  output reg irq
);
  // Configuration registers.
  reg [7:0] fast_input_type_select;
  reg [1:0] input_a_function_select;
  reg [1:0] input_b_function_select;
  reg speed_sense_source;
  reg [1:0] encoder_direction_invert;
  reg [15:0] encoder_lines_per_rev;
  reg [CNT_W-1:0] count_target;
  reg [2:0] status;
  reg [2:0] mask;

  // Block state.
  // Position counts both ways as a signed two's complement value.
  reg [CNT_W-1:0] pulse_count;
  reg signed [31:0] position;
  reg signed [31:0] gate_start;
  reg signed [15:0] encoder_frequency_readout;
  reg [31:0] index_pulse_count;
  reg [31:0] gate_cnt;
  reg index_d;

  // Pin edges.
  wire a_lvl;
  wire a_rise;
  wire a_fall;
  wire b_lvl;

  // Mode decode and stepping.
  wire a_pulse_mode;
  wire b_pulse_mode;
  wire enc_mode;
  wire cnt_mode;
  wire dir_raw;
  wire step;
  wire up;
  wire index_evt;
  wire gate_end;
  wire reach;

  // Frequency arithmetic.
  wire signed [31:0] delta;
  wire signed [31:0] delta_scaled;
  wire signed [16:0] lines_signed;
  wire signed [31:0] freq_raw;
  reg signed [15:0] next_freq;
  // Tenths of a hertz per edge and line with the default gate; see the readout below.
  localparam signed [31:0] FREQ_SCALE = 32'sd50;

  // Edge detector for pin A, whose edges drive counting and stepping.
  lpei_edge u_edge_a
  (
    .core_clk(core_clk),
    .srst(srst),
    .pin(fast_input_a),
    .level(a_lvl),
    .rise(a_rise),
    .fall(a_fall)
  );

  // Pin B only needs its level, since position steps on A edges alone.
  lpei_edge u_edge_b
  (
    .core_clk(core_clk),
    .srst(srst),
    .pin(fast_input_b),
    .level(b_lvl),
    .rise(),
    .fall()
  );

  // Input roles from the type and function settings.
  // The reserved function code selects neither counting nor the encoder pair.
  assign a_pulse_mode = ~fast_input_type_select[`LPEI_TYPE_A_BIT];
  assign b_pulse_mode = ~fast_input_type_select[`LPEI_TYPE_B_BIT];
  assign enc_mode = a_pulse_mode & b_pulse_mode
    & (input_a_function_select == `LPEI_FUNC_ENC)
    & (input_b_function_select == `LPEI_FUNC_ENC);
  assign cnt_mode = a_pulse_mode & (input_a_function_select == `LPEI_FUNC_FREQ);

  // Quadrature decode on every edge of A; A leads B, counting up, when A differs from B
  // after the edge. Stepping on A alone gives two counts per line, and a chattering B line
  // cannot walk the position while A stands still.
  assign step = enc_mode & (a_rise | a_fall);
  assign dir_raw = (fast_input_a != b_lvl);
  assign up = dir_raw ^ encoder_direction_invert[`LPEI_INV_DIR_BIT];
  assign index_evt = enc_mode & index_pulse & ~index_d;
  assign gate_end = (gate_cnt == GATE_CYC - 1);
  // The edge of the same cycle is counted, so the reached pulse is not a cycle late.
  assign reach = cnt_mode & ((pulse_count + {{(CNT_W-1){1'b0}}, a_rise}) >= count_target);

  // Edges of A per gate of 100 ms: a revolution gives 2 * lines edges, and one revolution
  // per gate is 10 Hz, or 100 steps of 0.1 Hz, so the readout is 50 * delta / lines.
  // A lines setting of zero would divide by zero, so the readout then stays at 0.
  assign delta = position - gate_start;
  assign delta_scaled = delta * FREQ_SCALE;
  assign lines_signed = {1'b0, encoder_lines_per_rev};
  assign freq_raw = (encoder_lines_per_rev == 16'h0000) ? 32'sd0 :
    delta_scaled / lines_signed;

  // Clamp the measured frequency into the reported range.
  // Values beyond the range would wrap in 16 bits, so they are pinned to its ends.
  always @*
  begin
    next_freq = freq_raw[15:0];
    if (freq_raw > 32'sd32767)
      next_freq = `LPEI_FREQ_MAX;
    else if (freq_raw < -32'sd9999)
      next_freq = `LPEI_FREQ_MIN;
  end

  // Register writes and configuration.
  // The type setting keeps only its bits 0 and 4; writes to read-only or unmapped
  // offsets are ignored, and the target resets to all ones so nothing is reached early.
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      fast_input_type_select <= `LPEI_TYPE_RST;
      input_a_function_select <= `LPEI_FUNC_RST;
      input_b_function_select <= `LPEI_FUNC_RST;
      speed_sense_source <= `LPEI_SENSE_CARD;
      encoder_direction_invert <= 2'h0;
      encoder_lines_per_rev <= 16'h0400;
      count_target <= {CNT_W{1'b1}};
      mask <= 3'h0;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `LPEI_REG_TYPE: fast_input_type_select <= reg_wdata[7:0] & 8'h11;
        `LPEI_REG_FUNC_A: input_a_function_select <= reg_wdata[1:0];
        `LPEI_REG_FUNC_B: input_b_function_select <= reg_wdata[1:0];
        `LPEI_REG_SENSE: speed_sense_source <= reg_wdata[0];
        `LPEI_REG_INVERT: encoder_direction_invert <= reg_wdata[1:0];
        `LPEI_REG_TARGET: count_target <= reg_wdata[CNT_W-1:0];
        `LPEI_REG_MASK: mask <= reg_wdata[2:0];
        `LPEI_REG_LINES: encoder_lines_per_rev <= reg_wdata[15:0];
        default: mask <= mask;
      endcase
    end
  end

  // Pulse counting against the target, with the reached pulse.
  // Leaving counting mode clears the count, so a later return starts again from zero.
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      pulse_count <= {CNT_W{1'b0}};
      count_reached <= 1'b0;
    end
    else
    begin
      count_reached <= reach;
      if (!cnt_mode)
        pulse_count <= {CNT_W{1'b0}};
      else if (reach)
        pulse_count <= {CNT_W{1'b0}};
      else if (a_rise)
        pulse_count <= pulse_count + 1'b1;
    end
  end

  // Position, index capture and frequency gate.
  // The index direction bit changes only the captured reference, never the position, and
  // the gate runs in every mode so the readout falls back to 0 by the second gate end after the pair stops.
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      position <= 32'sd0;
      gate_start <= 32'sd0;
      gate_cnt <= 32'h0;
      encoder_frequency_readout <= 16'sd0;
      index_pulse_count <= 32'h0;
      index_d <= 1'b0;
    end
    else
    begin
      index_d <= index_pulse;
      if (step)
        position <= up ? position + 32'sd1 : position - 32'sd1;
      if (index_evt)
      begin
        if (encoder_direction_invert[`LPEI_INV_IDX_BIT])
          index_pulse_count <= -position;
        else
          index_pulse_count <= position;
      end
      if (gate_end)
      begin
        gate_cnt <= 32'h0;
        gate_start <= position;
        encoder_frequency_readout <= enc_mode ? next_freq : 16'sd0;
      end
      else
        gate_cnt <= gate_cnt + 32'h1;
    end
  end

  // Sticky status, write one to clear; a new event wins over the clear.
  // Bit 2 is set on every gate end and is meant as a periodic tick, so it is usually masked.
  always @(posedge core_clk)
  begin
    if (srst)
      status <= 3'h0;
    else
      status <= (status & ~((reg_wr && reg_addr == `LPEI_REG_STATUS) ? reg_wdata[2:0] : 3'h0))
        | {gate_end, index_evt, reach};
  end

  // Registered outputs and read data.
  // Read data stand for one cycle and then return to zero, so a late sample never sees stale
  // data; a pin in pulse mode shows 0 on its digital output.
  always @(posedge core_clk)
  begin
    if (srst)
    begin
      irq <= 1'b0;
      digital_a <= 1'b0;
      digital_b <= 1'b0;
      speed_feedback <= 16'h0;
      reg_rdata <= 32'h0;
    end
    else
    begin
      irq <= |(status & mask);
      digital_a <= ~a_pulse_mode & a_lvl;
      digital_b <= ~b_pulse_mode & b_lvl;
      speed_feedback <= (speed_sense_source == `LPEI_SENSE_LOCAL) ?
        encoder_frequency_readout : card_frequency;
      reg_rdata <= 32'h0;
      if (reg_rd)
      begin
        case (reg_addr)
          `LPEI_REG_TYPE: reg_rdata <= {24'h0, fast_input_type_select};
          `LPEI_REG_FUNC_A: reg_rdata <= {30'h0, input_a_function_select};
          `LPEI_REG_FUNC_B: reg_rdata <= {30'h0, input_b_function_select};
          `LPEI_REG_SENSE: reg_rdata <= {31'h0, speed_sense_source};
          `LPEI_REG_INVERT: reg_rdata <= {30'h0, encoder_direction_invert};
          `LPEI_REG_TARGET: reg_rdata <= count_target;
          `LPEI_REG_COUNT: reg_rdata <= pulse_count;
          `LPEI_REG_FREQ: reg_rdata <= {{16{encoder_frequency_readout[15]}},
            encoder_frequency_readout};
          `LPEI_REG_INDEX: reg_rdata <= index_pulse_count;
          `LPEI_REG_POS: reg_rdata <= position;
          `LPEI_REG_STATUS: reg_rdata <= {29'h0, status};
          `LPEI_REG_MASK: reg_rdata <= {29'h0, mask};
          `LPEI_REG_PINS: reg_rdata <= {30'h0, b_lvl, a_lvl};
          `LPEI_REG_LINES: reg_rdata <= {16'h0, encoder_lines_per_rev};
          default: reg_rdata <= 32'h0;
        endcase
      end
    end
  end
endmodule // lpei_top

// [verif/lpei_checker.sv]
// Port assertions for the local pulse and encoder input block.
`timescale 1ns/1ns
module lpei_checker
#(
  parameter GATE_CYC = 1000000,
  parameter CNT_W = 32
)
(
  // Clock and reset.
  input wire core_clk,
  input wire srst,
  // Pins.
  input wire fast_input_a,
  input wire fast_input_b,
  input wire index_pulse,
  input wire [15:0] card_frequency,
  // Register port.
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  input wire [31:0] reg_rdata,
  // Outputs.
  input wire count_reached,
  input wire digital_a,
  input wire digital_b,
  input wire [15:0] speed_feedback,
  input wire irq
);
  reg [1:0] typ;
  reg [2:0] msk;
  reg sen;
  // Shadow copies of the settings written over the register port.
  always @(posedge core_clk)
    if (srst)
    begin
      typ <= 2'h0;
      msk <= 3'h0;
      sen <= 1'b0;
    end
    else if (reg_wr)
    begin
      if (reg_addr == 4'h0) typ <= {reg_wdata[4], reg_wdata[0]};
      if (reg_addr == 4'hb) msk <= reg_wdata[2:0];
      if (reg_addr == 4'h3) sen <= reg_wdata[0];
    end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // A reach event while its interrupt is enabled.
  sequence reach_s;
    count_reached && msk[0];
  endsequence
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  reach_one_a: assert property (count_reached |=> !count_reached)
    else $error("reached pulse too long");
  reach_irq_a: assert property (reach_s |-> ##[0:3] irq)
    else $error("no interrupt after reach");
  irq_mask_a: assert property (msk == 3'h0 && $past(msk) == 3'h0 |-> !irq)
    else $error("interrupt while masked");
  dig_a_off_a: assert property (!typ[0] && !$past(typ[0]) |-> !digital_a)
    else $error("digital a in pulse mode");
  dig_b_off_a: assert property (!typ[1] && !$past(typ[1]) |-> !digital_b)
    else $error("digital b in pulse mode");
  spd_card_a: assert property (!$past(sen) && !$past(srst) |->
    speed_feedback == $past(card_frequency))
    else $error("card speed not passed on");
  freq_range_a: assert property ($past(sen) |-> $signed(speed_feedback) >= -16'sd9999)
    else $error("local speed below range");
endmodule // lpei_checker
bind lpei_top lpei_checker #(.GATE_CYC(GATE_CYC), .CNT_W(CNT_W)) chk_i (.core_clk(core_clk),
  .srst(srst), .fast_input_a(fast_input_a), .fast_input_b(fast_input_b),
  .index_pulse(index_pulse), .card_frequency(card_frequency), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .count_reached(count_reached), .digital_a(digital_a), .digital_b(digital_b),
  .speed_feedback(speed_feedback), .irq(irq));

// [verif/lpei_enc.sv]
// Model of the encoder or pulse source on the fast pins.
`timescale 1ns/1ns
module lpei_enc
(
  // Clock.
  input wire core_clk,
  // Encoder lines.
  output logic enc_a,
  output logic enc_b,
  output logic enc_z
);
  // Lines rest low until a task drives them.
  initial {enc_a, enc_b, enc_z} = 3'h0;
  // Quadrature steps; forward lets A lead B.
  task automatic quad(input bit fwd, input int n);
    for (int i = 0; i < n; i++)
    begin
      @(posedge core_clk);
      if (fwd == (enc_a == enc_b)) enc_a <= ~enc_a;
      else enc_b <= ~enc_b;
      repeat (4) @(posedge core_clk);
    end
  endtask
  // Square pulses on A for counting.
  task automatic pulse(input int n);
    repeat (n)
    begin
      @(posedge core_clk);
      enc_a <= 1;
      repeat (2) @(posedge core_clk);
      enc_a <= 0;
      repeat (4) @(posedge core_clk);
    end
  endtask
  // Static levels for digital use.
  task automatic lev(input bit a, input bit b);
    @(posedge core_clk);
    enc_a <= a;
    enc_b <= b;
  endtask
  // One index pulse.
  task automatic idx;
    @(posedge core_clk);
    enc_z <= 1;
    repeat (2) @(posedge core_clk);
    enc_z <= 0;
    repeat (4) @(posedge core_clk);
  endtask
endmodule // lpei_enc

// [verif/lpei_top_tb.sv]
// Self-checking bench for the local pulse and encoder input block.
`timescale 1ns/1ns
module lpei_top_tb;
  logic core_clk = 0, srst = 1, reg_wr = 0, reg_rd = 0;
  logic [3:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, v;
  logic [15:0] card_frequency = 16'h0123;
  wire [31:0] reg_rdata;
  wire [15:0] speed_feedback;
  wire a, b, z, count_reached, digital_a, digital_b, irq;
  int n_errors = 0, check_count = 0, n_reach = 0;
  // Clock and a tally of reached pulses.
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) if (count_reached) n_reach++;
  lpei_enc enc (.core_clk(core_clk), .enc_a(a), .enc_b(b), .enc_z(z));
  lpei_top #(.GATE_CYC(100)) dut (.core_clk(core_clk), .srst(srst), .fast_input_a(a),
    .fast_input_b(b), .index_pulse(z), .card_frequency(card_frequency), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .count_reached(count_reached), .digital_a(digital_a), .digital_b(digital_b),
    .speed_feedback(speed_feedback), .irq(irq));
  task chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value %s exp %h seen %h", s, exp, seen);
    end
  endtask
  task wr(input logic [3:0] ad, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1;
    @(posedge core_clk);
    reg_wr <= 0;
  endtask
  task rd(input logic [3:0] ad);
    @(posedge core_clk);
    reg_addr <= ad;
    reg_rd <= 1;
    @(posedge core_clk);
    reg_rd <= 0;
    @(negedge core_clk);
    v = reg_rdata;
  endtask
  task rc(input logic [3:0] ad, input string s, input logic [31:0] e);
    rd(ad);
    chk(s, v, e);
  endtask
  task t_reset;
    rc(4'h0, "type", 0);
    rc(4'h1, "func a", 0);
    rc(4'h2, "func b", 0);
    rc(4'h7, "freq", 0);
    rc(4'he, "unmapped", 0);
    chk("speed", speed_feedback, 16'h0123);
    @(posedge core_clk);
    card_frequency <= 16'h8765;
    repeat (2) @(posedge core_clk);
    chk("speed new", speed_feedback, 16'h8765);
    wr(4'h0, 32'hff);
    rc(4'h0, "type mask", 32'h11);
  endtask
  task t_dig;
    enc.lev(1, 0);
    for (int i = 0; i < 9 && !digital_a; i++) @(posedge core_clk);
    chk("dig ab", {digital_a, digital_b}, 2);
    enc.lev(0, 1);
    for (int i = 0; i < 9 && !digital_b; i++) @(posedge core_clk);
    chk("dig ba", {digital_a, digital_b}, 1);
    wr(4'h0, 0);
    for (int i = 0; i < 9 && digital_b; i++) @(posedge core_clk);
    chk("dig off", digital_b, 0);
  endtask
  task t_cnt;
    enc.lev(0, 0);
    wr(4'h5, 3);
    wr(4'hb, 1);
    enc.pulse(2);
    rc(4'h6, "count", 2);
    chk("early", n_reach, 0);
    enc.pulse(1);
    for (int i = 0; i < 9 && n_reach == 0; i++) @(posedge core_clk);
    chk("reached", n_reach, 1);
    rc(4'h6, "cleared", 0);
    chk("irq set", irq, 1);
    wr(4'hb, 0);
    rd(4'ha);
    chk("masked", irq, 0);
    chk("sticky", v[0], 1);
    wr(4'hb, 1);
    rd(4'ha);
    chk("unmasked", irq, 1);
    wr(4'ha, 1);
    rd(4'ha);
    chk("status clr", v[0], 0);
    chk("irq low", irq, 0);
  endtask
  task t_enc;
    wr(4'h1, 2);
    wr(4'h2, 2);
    wr(4'hd, 32'd4096);
    rc(4'hd, "lines", 32'd4096);
    enc.quad(1, 8);
    rc(4'h9, "pos fwd", 4);
    enc.quad(0, 4);
    rc(4'h9, "pos rev", 2);
    wr(4'h4, 1);
    enc.quad(1, 8);
    rc(4'h9, "pos inv", 32'hfffffffe);
    enc.idx;
    rc(4'h8, "index", 32'hfffffffe);
    wr(4'h4, 3);
    enc.idx;
    rc(4'h8, "index rev", 2);
  endtask
  // Ten A edges per gate on one line give 50 * 10 / 1 = 500 tenths of a hertz.
  task t_freq(input bit inv);
    logic [31:0] f;
    f = inv ? 32'hfffffe0c : 32'h000001f4;
    wr(4'hd, 1);
    wr(4'h3, 1);
    wr(4'h4, {31'h0, inv});
    fork
      enc.quad(1, 80);
    join_none
    repeat (260) @(posedge core_clk);
    rc(4'h7, "freq mid", f);
    chk("freq run", speed_feedback, f[15:0]);
    chk("freq sign", v[31], inv);
    chk("spd sign", speed_feedback[15], inv);
    wait fork;
    repeat (210) @(posedge core_clk);
    rc(4'h7, "freq stop", 0);
  endtask
  task complete_run;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence after ten reset cycles.
  initial
  begin
    repeat (10) @(posedge core_clk);
    srst <= 0;
    t_reset;
    t_dig;
    t_cnt;
    t_enc;
    t_freq(1);
    t_freq(0);
    complete_run;
  end
  // Watchdog against a hang.
  initial
  begin
    repeat (20000) @(posedge core_clk);
    n_errors++;
    complete_run;
  end
endmodule // lpei_top_tb
